/* File: core_model.sv */
// core model issuing i/o accesses, bus cycles and fetch ends
`timescale 1ns/1ps
module core_model (
    // clock
    input  wire logic             sys_clk_i,
    // i/o access
    output logic                  wr_o,
    output logic                  rd_o,
    output logic [7:0]            addr_o,
    output logic [7:0]            wdata_o,
    // bus cycles
    output logic                  start_o,
    output sysctl_pkg::cyc_kind_t kind_o,
    output logic [15:0]           caddr_o,
    output logic                  fend_o,
    output logic [7:0]            op_o
);
    import sysctl_pkg::*;
    initial begin
        {wr_o, rd_o, addr_o, wdata_o, start_o, caddr_o, fend_o, op_o} = '0;
        kind_o = CYC_NONE;
    end
    // released lines carry the inverse so stale values never look valid
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(negedge sys_clk_i);
        {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    endtask : io
    task automatic cyc(input cyc_kind_t k, input logic [15:0] a);
        @(negedge sys_clk_i);
        {start_o, caddr_o} = {1'b1, a};
        kind_o = k;
        @(negedge sys_clk_i);
        {start_o, caddr_o} = {1'b0, ~a};
        kind_o = CYC_NONE;
    endtask : cyc
    task automatic fetch(input logic [7:0] op);
        @(negedge sys_clk_i);
        {fend_o, op_o} = {1'b1, op};
        @(negedge sys_clk_i);
        {fend_o, op_o} = {1'b0, ~op};
    endtask : fetch
endmodule : core_model

/* File: sysctl_if.sv */
// signals between the register bank, the wait generator and the watchdog counter
`timescale 1ns/1ps
interface sysctl_if;
    logic [7:0] wait_ctrl;
    logic [7:0] mem_bound;
    logic       onchip;
    logic       wdt_run;
    logic       wdt_clear;
    logic [1:0] wdt_period;
    modport regs  (output wait_ctrl, mem_bound, onchip, wdt_run, wdt_clear, wdt_period);
    modport waits (input wait_ctrl, mem_bound, onchip);
    modport dog   (input wdt_run, wdt_clear, wdt_period);
endinterface : sysctl_if

/* File: sysctl_map.svh */
// register map, keys, field positions, reset values and timing counts of system control
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH
`define ADDR_WDT_MASTER 8'hf0
`define ADDR_WDT_KEY    8'hf1
`define ADDR_CHAIN      8'hf4
`define ADDR_PTR        8'hee
`define ADDR_DATA       8'hef
`define ONCHIP_LO       8'h10
`define ONCHIP_HI       8'h1f
`define IDX_WAIT        8'h00
`define IDX_MEMB        8'h01
`define IDX_CSB         8'h02
`define IDX_MISC        8'h03
`define KEY_DISABLE     8'hb1
`define KEY_CLEAR       8'h4e
`define KEY_HALT        8'hdb
`define OP_PREFIX       8'hed
`define OP_RETURN       8'h4d
`define MASTER_RSVD     3'h3
`define MISC_MASK       8'h1f
`define RST_PERIOD      2'h3
`define RST_CHAIN       3'h0
`define RST_PTR         8'h00
`define RST_WAIT        8'hff
`define RST_MEMB        8'hf0
`define RST_CSB         8'h0f
`define RST_MISC        8'h01
`define BOOT_LAST_FETCH 4'hf
`define WDT_EXP0        16
`define WDT_EXP1        18
`define WDT_EXP2        20
`define WDT_EXP3        22
`endif

/* File: sysctl_pkg.sv */
// types shared by the system control block
package sysctl_pkg;
    typedef enum logic [2:0] {CYC_NONE, CYC_FETCH, CYC_MEM, CYC_IO, CYC_INTACK} cyc_kind_t;
    typedef enum logic [1:0] {HALT_IDLE1, HALT_IDLE2, HALT_STOP, HALT_RUN} halt_mode_t;
    typedef enum logic {BOOT_FORCED, BOOT_DONE} boot_state_t;
endpackage : sysctl_pkg

/* File: system_control_wdt_wait_regs.sv */
// system control registers: watchdog keys, chain order, config pointer and wait control
`timescale 1ns/1ps
`include "sysctl_map.svh"
module system_control_wdt_wait_regs #(
    parameter int unsigned WDT_PERIOD0 = 32'd1 << `WDT_EXP0,
    parameter int unsigned WDT_PERIOD1 = 32'd1 << `WDT_EXP1,
    parameter int unsigned WDT_PERIOD2 = 32'd1 << `WDT_EXP2,
    parameter int unsigned WDT_PERIOD3 = 32'd1 << `WDT_EXP3
) (
    // clock, reset, enable
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   ce_i,
    // on-chip i/o access from the core
    input  wire logic                   io_wr_i,
    input  wire logic                   io_rd_i,
    input  wire logic [7:0]             io_addr_i,
    input  wire logic [7:0]             io_wdata_i,
    output logic      [7:0]             io_rdata_o,
    output logic                        io_claim_o,
    // bus cycle announcements for wait insertion
    input  wire logic                   cyc_start_i,
    input  wire sysctl_pkg::cyc_kind_t  cyc_kind_i,
    input  wire logic [15:0]            cyc_addr_i,
    input  wire logic                   fetch_end_i,
    input  wire logic [7:0]             fetch_opcode_i,
    output logic                        wait_o,
    // control toward the rest of the device
    output logic                        wdt_timeout_o,
    output sysctl_pkg::halt_mode_t      halt_mode_o,
    output logic      [2:0]             chain_order_o,
    output logic      [7:0]             mem_bound_o,
    output logic      [7:0]             cs_bound_o,
    output logic      [7:0]             misc_ctrl_o
);
    import sysctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic        wdt_en_ff;
    logic [1:0]  wdt_period_ff;
    halt_mode_t  halt_ff;
    logic        wdt_run_ff;
    logic        halt_armed_ff;
    logic [2:0]  chain_ff;
    logic [7:0]  ptr_ff;
    logic [7:0]  wait_ctrl_ff;
    logic [7:0]  memb_ff;
    logic [7:0]  csb_ff;
    logic [7:0]  misc_ff;
    boot_state_t boot_ff;
    logic [3:0]  fetch_cnt_ff;
    logic [7:0]  rdata_ff;
    logic        claim_ff;

    // decode
    logic        wr_master;
    logic        wr_key;
    logic        wr_chain;
    logic        wr_ptr;
    logic        wr_data;
    logic        wr_wait;
    logic        wr_any;
    logic        key_disable;
    logic        key_clear;
    logic        key_halt;
    logic        rd_hit;
    logic [7:0]  rd_val;
    logic [7:0]  cyc_port;

    sysctl_if sif ();

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode of the core's i/o writes
    assign wr_master   = io_wr_i && (io_addr_i == `ADDR_WDT_MASTER);
    assign wr_key      = io_wr_i && (io_addr_i == `ADDR_WDT_KEY);
    assign wr_chain    = io_wr_i && (io_addr_i == `ADDR_CHAIN);
    assign wr_ptr      = io_wr_i && (io_addr_i == `ADDR_PTR);
    assign wr_data     = io_wr_i && (io_addr_i == `ADDR_DATA);
    assign wr_wait     = wr_data && (ptr_ff == `IDX_WAIT);
    assign wr_any      = wr_master || wr_key || wr_chain || wr_ptr || wr_data;
    assign key_disable = wr_key && (io_wdata_i == `KEY_DISABLE);
    assign key_clear   = wr_key && (io_wdata_i == `KEY_CLEAR);
    assign key_halt    = wr_key && (io_wdata_i == `KEY_HALT);

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog master fields
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wdt_en_ff     <= 1'b1;
            wdt_period_ff <= `RST_PERIOD;
            halt_ff       <= HALT_RUN;
        end else if (ce_i && wr_master) begin
            wdt_en_ff     <= io_wdata_i[7];
            wdt_period_ff <= io_wdata_i[6:5];
            if (halt_armed_ff) begin
                halt_ff <= halt_mode_t'(io_wdata_i[4:3]);
            end
        end
    end

    // clearing the enable bit alone must not stop the count; runaway code rarely hits two keys
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wdt_run_ff <= 1'b1;
        end else if (ce_i) begin
            if (wr_master && io_wdata_i[7]) begin
                wdt_run_ff <= 1'b1;
            end else if (key_disable && !wdt_en_ff) begin
                wdt_run_ff <= 1'b0;
            end
        end
    end

    // the mode key only holds until the very next i/o write of any kind
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            halt_armed_ff <= 1'b0;
        end else if (ce_i && io_wr_i) begin
            halt_armed_ff <= key_halt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // chain order and config pointer
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            chain_ff <= `RST_CHAIN;
        end else if (ce_i && wr_chain) begin
            chain_ff <= io_wdata_i[2:0];
        end
    end

    // reserved pointer values are stored as written; the data port then reads zero
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ptr_ff <= `RST_PTR;
        end else if (ce_i && wr_ptr) begin
            ptr_ff <= io_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // indirect config registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            memb_ff <= `RST_MEMB;
            csb_ff  <= `RST_CSB;
            misc_ff <= `RST_MISC;
        end else if (ce_i && wr_data) begin
            case (ptr_ff)
                `IDX_MEMB: memb_ff <= io_wdata_i;
                `IDX_CSB:  csb_ff  <= io_wdata_i;
                `IDX_MISC: misc_ff <= io_wdata_i & `MISC_MASK;
                default:   ;
            endcase
        end
    end

    // a software write in the 16th fetch cycle wins over the automatic clear
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wait_ctrl_ff <= `RST_WAIT;
            boot_ff      <= BOOT_FORCED;
            fetch_cnt_ff <= 4'h0;
        end else if (ce_i) begin
            if (wr_wait) begin
                wait_ctrl_ff <= io_wdata_i;
                boot_ff      <= BOOT_DONE;
            end else begin
                case (boot_ff)
                    BOOT_FORCED: begin
                        if (fetch_end_i) begin
                            fetch_cnt_ff <= fetch_cnt_ff + 4'h1;
                            if (fetch_cnt_ff == `BOOT_LAST_FETCH) begin
                                wait_ctrl_ff <= 8'h00;
                                boot_ff      <= BOOT_DONE;
                            end
                        end
                    end
                    BOOT_DONE: ;
                    default:   boot_ff <= BOOT_DONE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read side; write-only addresses are not claimed on reads
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
        case (io_addr_i)
            `ADDR_WDT_MASTER: begin
                rd_hit = 1'b1;
                rd_val = {wdt_en_ff, wdt_period_ff, halt_ff, `MASTER_RSVD};
            end
            `ADDR_PTR: begin
                rd_hit = 1'b1;
                rd_val = ptr_ff;
            end
            `ADDR_DATA: begin
                rd_hit = 1'b1;
                case (ptr_ff)
                    `IDX_WAIT: rd_val = wait_ctrl_ff;
                    `IDX_MEMB: rd_val = memb_ff;
                    `IDX_CSB:  rd_val = csb_ff;
                    `IDX_MISC: rd_val = misc_ff;
                    default:   rd_val = 8'h00;
                endcase
            end
            default: ;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
            claim_ff <= 1'b0;
        end else if (ce_i) begin
            claim_ff <= (io_rd_i && rd_hit) || wr_any;
            if (io_rd_i) begin
                rdata_ff <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // on-chip i/o decode for the wait generator, only the low address byte counts
    assign cyc_port = cyc_addr_i[7:0];
    assign sif.onchip = (cyc_port >= `ONCHIP_LO && cyc_port <= `ONCHIP_HI)
                     || cyc_port == `ADDR_WDT_MASTER || cyc_port == `ADDR_WDT_KEY
                     || cyc_port == `ADDR_CHAIN || cyc_port == `ADDR_PTR
                     || cyc_port == `ADDR_DATA;
    assign sif.wait_ctrl  = wait_ctrl_ff;
    assign sif.mem_bound  = memb_ff;
    assign sif.wdt_run    = wdt_run_ff;
    assign sif.wdt_clear  = key_clear;
    assign sif.wdt_period = wdt_period_ff;

    wait_gen u_wait (
        .sys_clk_i      (sys_clk_i),
        .resetn_i       (resetn_i),
        .ce_i           (ce_i),
        .sif            (sif),
        .cyc_start_i    (cyc_start_i),
        .cyc_kind_i     (cyc_kind_i),
        .cyc_addr_i     (cyc_addr_i),
        .fetch_end_i    (fetch_end_i),
        .fetch_opcode_i (fetch_opcode_i),
        .wait_o         (wait_o)
    );

    watchdog_core #(
        .PERIOD0 (WDT_PERIOD0),
        .PERIOD1 (WDT_PERIOD1),
        .PERIOD2 (WDT_PERIOD2),
        .PERIOD3 (WDT_PERIOD3)
    ) u_dog (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .sif       (sif),
        .timeout_o (wdt_timeout_o)
    );

    assign io_rdata_o    = rdata_ff;
    assign io_claim_o    = claim_ff;
    assign halt_mode_o   = halt_ff;
    assign chain_order_o = chain_ff;
    assign mem_bound_o   = memb_ff;
    assign cs_bound_o    = csb_ff;
    assign misc_ctrl_o   = misc_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence halt_key_s;
        ce_i && key_halt;
    endsequence
    sequence master_wr_s;
        ce_i && wr_master;
    endsequence

    wdt_start_a: assert property (master_wr_s and io_wdata_i[7] |=> wdt_run_ff)
        else $error("watchdog not started by enable bit");

    wdt_stop_a: assert property (ce_i && key_disable && !wdt_en_ff |=> !wdt_run_ff)
        else $error("watchdog not stopped by disable key");

    wdt_keep_a: assert property (
        master_wr_s and !io_wdata_i[7] |=> wdt_run_ff == $past(wdt_run_ff))
        else $error("enable bit alone changed run state");

    reset_values_a: assert property ($rose(resetn_i) |-> wdt_run_ff && wdt_en_ff
        && wdt_period_ff == 2'h3 && halt_ff == HALT_RUN && chain_ff == 3'h0 && ptr_ff == 8'h00)
        else $error("wrong power-on values");

    // the key and the master write may be split by one idle bus cycle
    halt_key_a: assert property (
        halt_key_s ##1 !io_wr_i ##1 master_wr_s |=> halt_ff == halt_mode_t'($past(io_wdata_i[4:3])))
        else $error("halt mode not taken after key");

    halt_lock_a: assert property (master_wr_s and !halt_armed_ff |=> $stable(halt_ff))
        else $error("halt mode changed without key");

    rsvd_read_a: assert property (
        ce_i && io_rd_i && io_addr_i == `ADDR_WDT_MASTER |=> io_rdata_o[2:0] == 3'h3 && io_claim_o)
        else $error("reserved bits not 011");

    key_wo_a: assert property (
        ce_i && io_rd_i && !io_wr_i && io_addr_i == `ADDR_WDT_KEY |=> !io_claim_o)
        else $error("command register answered a read");

    ptr_hold_a: assert property (ce_i && !wr_ptr |=> $stable(ptr_ff))
        else $error("pointer changed without a write");

    boot_clear_a: assert property (
        ce_i && boot_ff == BOOT_FORCED && fetch_end_i && fetch_cnt_ff == 4'hf && !wr_wait
        |=> wait_ctrl_ff == 8'h00 && boot_ff == BOOT_DONE)
        else $error("wait control not cleared at 16th fetch");

    boot_forced_a: assert property (
        boot_ff == BOOT_FORCED |-> wait_ctrl_ff == `RST_WAIT)
        else $error("wait control not all ones during boot");

    wait_write_a: assert property (
        ce_i && wr_wait |=> wait_ctrl_ff == $past(io_wdata_i) && boot_ff == BOOT_DONE)
        else $error("wait control not written through data port");

    chain_write_a: assert property (
        ce_i && wr_chain |=> chain_ff == $past(io_wdata_i[2:0]))
        else $error("chain order not written");

    period_write_a: assert property (
        master_wr_s |=> wdt_period_ff == $past(io_wdata_i[6:5]))
        else $error("watchdog period not written");

    misc_write_a: assert property (
        ce_i && wr_data && ptr_ff == `IDX_MISC |=> misc_ff == ($past(io_wdata_i) & `MISC_MASK))
        else $error("misc control write not masked");

    state_freeze_a: assert property (
        !ce_i |=> $stable(ptr_ff) && $stable(chain_ff) && $stable(wait_ctrl_ff) && $stable(halt_ff))
        else $error("state changed with clock enable low");
endmodule : system_control_wdt_wait_regs

/* File: system_control_wdt_wait_regs_bench.sv */
// self-checking bench for the system control register block
`timescale 1ns/1ps
module system_control_wdt_wait_regs_bench;
    import sysctl_pkg::*;
    logic        sys_clk_i, resetn_i, wr, rd, start, fend, claim, wt, tmo, ce;
    logic [7:0]  addr, wdata, op, rdata, memb, csb, misc;
    logic [15:0] caddr;
    logic [2:0]  chain;
    cyc_kind_t   kind;
    halt_mode_t  halt;
    int          bad_count = 0, n_checks = 0, cnt;
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    core_model core (.sys_clk_i(sys_clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .wdata_o(wdata), .start_o(start), .kind_o(kind), .caddr_o(caddr), .fend_o(fend),
        .op_o(op));
    // short watchdog periods keep the run brief
    system_control_wdt_wait_regs #(.WDT_PERIOD0(16), .WDT_PERIOD1(32), .WDT_PERIOD2(64),
        .WDT_PERIOD3(128)) DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .io_wr_i(wr), .io_rd_i(rd), .io_addr_i(addr), .io_wdata_i(wdata), .io_rdata_o(rdata),
        .io_claim_o(claim), .cyc_start_i(start), .cyc_kind_i(kind), .cyc_addr_i(caddr),
        .fetch_end_i(fend), .fetch_opcode_i(op), .wait_o(wt), .wdt_timeout_o(tmo),
        .halt_mode_o(halt), .chain_order_o(chain), .mem_bound_o(memb), .cs_bound_o(csb),
        .misc_ctrl_o(misc));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        core.io(1'b0, a, 8'h00);
        chk(rdata, exp);
        chk({7'h0, claim}, {7'h0, a != 8'hf1 && a != 8'hf4});
    endtask : rd_chk
    // window of twelve covers the longest load of seven
    task automatic cw(input cyc_kind_t k, input logic [15:0] a, input int n);
        if (k != CYC_NONE) core.cyc(k, a);
        cnt = 0;
        repeat (12) begin
            cnt += (wt === 1'b1);
            @(negedge sys_clk_i);
        end
        chk(cnt[7:0], n[7:0]);
    endtask : cw
    task automatic tmos(input int span, input int n);
        cnt = 0;
        repeat (span) begin
            @(negedge sys_clk_i);
            cnt += (tmo === 1'b1);
        end
        chk(cnt[7:0], n[7:0]);
    endtask : tmos
    task automatic t_boot;
        rd_chk(8'hf0, 8'hfb);
        rd_chk(8'hee, 8'h00);
        chk(memb, 8'hf0);
        chk(csb, 8'h0f);
        chk(misc, 8'h01);
        cw(CYC_IO, 16'h0080, 6);
        cw(CYC_IO, 16'h0012, 0);
        cw(CYC_INTACK, 16'h0000, 7);
        cw(CYC_FETCH, 16'h8000, 4);
        repeat (15) core.fetch(8'h00);
        rd_chk(8'hef, 8'hff);
        core.fetch(8'h00);
        rd_chk(8'hef, 8'h00);
        $display("boot test done");
    endtask : t_boot
    task automatic t_prog;
        core.io(1'b1, 8'hef, 8'h9d);
        cw(CYC_IO, 16'h00a0, 2);
        cw(CYC_INTACK, 16'h0000, 4);
        cw(CYC_MEM, 16'hf000, 3);
        core.fetch(8'hed);
        core.fetch(8'h4d);
        cw(CYC_NONE, 16'h0000, 2);
        core.fetch(8'hed);
        core.fetch(8'h07);
        cw(CYC_NONE, 16'h0000, 1);
        core.io(1'b1, 8'hee, 8'h01);
        core.io(1'b1, 8'hef, 8'h42);
        rd_chk(8'hef, 8'h42);
        chk(memb, 8'h42);
        cw(CYC_MEM, 16'h5000, 0);
        cw(CYC_FETCH, 16'h5000, 1);
        core.io(1'b1, 8'hee, 8'h02);
        core.io(1'b1, 8'hef, 8'ha5);
        chk(csb, 8'ha5);
        core.io(1'b1, 8'hee, 8'h03);
        core.io(1'b1, 8'hef, 8'hff);
        chk(misc, 8'h1f);
        rd_chk(8'hef, 8'h1f);
        core.io(1'b1, 8'hee, 8'h00);
        core.io(1'b1, 8'hef, 8'h60);
        cw(CYC_INTACK, 16'h0000, 3);
        $display("wait test done");
    endtask : t_prog
    task automatic t_halt;
        for (int i = 0; i < 4; i++) begin
            core.io(1'b1, 8'hf1, 8'hdb);
            core.io(1'b1, 8'hf0, {3'b111, i[1:0], 3'b011});
            chk(halt, i[7:0]);
        end
        core.io(1'b1, 8'hf1, 8'hdb);
        core.io(1'b1, 8'hf4, 8'h05);
        core.io(1'b1, 8'hf0, 8'he3);
        chk(halt, 8'h03);
        chk({5'h0, chain}, 8'h05);
        rd_chk(8'hf4, 8'h00);
        rd_chk(8'hf1, 8'h00);
        ce = 1'b0;
        core.io(1'b1, 8'hf4, 8'h02);
        chk({5'h0, chain}, 8'h05);
        chk({7'h0, claim}, 8'h00);
        ce = 1'b1;
        $display("halt test done");
    endtask : t_halt
    task automatic t_wdt;
        core.io(1'b1, 8'hf1, 8'h4e);
        core.io(1'b1, 8'hf0, 8'h9b);
        for (cnt = 0; tmo !== 1'b1 && cnt < 300; cnt++) @(negedge sys_clk_i);
        tmos(15, 0);
        tmos(1, 1);
        tmos(8, 0);
        core.io(1'b1, 8'hf1, 8'h4e);
        tmos(12, 0);
        core.io(1'b1, 8'hf0, 8'h1b);
        tmos(16, 1);
        core.io(1'b1, 8'hf1, 8'hb1);
        tmos(40, 0);
        core.io(1'b1, 8'hf0, 8'h9b);
        core.io(1'b1, 8'hf1, 8'h4e);
        tmos(20, 1);
        $display("watchdog test done");
    endtask : t_wdt
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        ce = 1'b1;
        resetn_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        t_boot;
        t_prog;
        t_halt;
        t_wdt;
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        bad_count++;
        report_and_stop;
    end
endmodule : system_control_wdt_wait_regs_bench

/* File: wait_gen.sv */
// wait state generator for fetch, memory, i/o, acknowledge and return cycles
`timescale 1ns/1ps
`include "sysctl_map.svh"
module wait_gen (
    // clock, reset, enable
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  ce_i,
    // settings from the register bank
    sysctl_if.waits                    sif,
    // bus cycle announcements
    input  wire logic                  cyc_start_i,
    input  wire sysctl_pkg::cyc_kind_t cyc_kind_i,
    input  wire logic [15:0]           cyc_addr_i,
    input  wire logic                  fetch_end_i,
    input  wire logic [7:0]            fetch_opcode_i,
    // wait request to the core
    output logic                       wait_o
);
    import sysctl_pkg::*;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [2:0] load;
    logic [2:0] mem_n;
    logic [2:0] ret_load;
    logic [1:0] chain;
    logic       prefix_ff;
    logic       in_bound;
    logic       ret_hit;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    assign chain    = sif.wait_ctrl[7:6];
    assign in_bound = (cyc_addr_i[15:12] <= sif.mem_bound[7:4])
                   && (cyc_addr_i[15:12] >= sif.mem_bound[3:0]);
    assign mem_n    = in_bound ? {1'b0, sif.wait_ctrl[3:2]} : 3'h0;
    assign ret_hit  = fetch_end_i && prefix_ff && chain[1];
    assign ret_load = (fetch_opcode_i == `OP_RETURN) ? (chain[0] ? 3'h4 : 3'h2) : 3'h1;

    always_comb begin
        case (cyc_kind_i)
            CYC_FETCH:  load = mem_n + {2'h0, sif.wait_ctrl[4]};
            CYC_MEM:    load = mem_n;
            CYC_IO:     load = sif.onchip ? 3'h0 : {sif.wait_ctrl[1:0], 1'b0};
            CYC_INTACK: load = {chain, 1'b0} + {2'h0, sif.wait_ctrl[5]};
            default:    load = 3'h0;
        endcase
        if (cyc_start_i) begin
            nxt_cnt = load;
        end else if (ret_hit) begin
            nxt_cnt = ret_load;
        end else if (cnt_ff != 3'h0) begin
            nxt_cnt = cnt_ff - 3'h1;
        end else begin
            nxt_cnt = 3'h0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_ff    <= 3'h0;
            wait_o    <= 1'b0;
            prefix_ff <= 1'b0;
        end else if (ce_i) begin
            cnt_ff <= nxt_cnt;
            wait_o <= (nxt_cnt != 3'h0);
            if (fetch_end_i) begin
                prefix_ff <= (fetch_opcode_i == `OP_PREFIX);
            end
        end
    end

    sequence io_start_s;
        ce_i && cyc_start_i && cyc_kind_i == CYC_IO;
    endsequence
    io_onchip_a: assert property (io_start_s and sif.onchip |=> !wait_o)
        else $error("wait inserted on on-chip i/o");
    io_wait_a: assert property (
        io_start_s and !sif.onchip && sif.wait_ctrl[1:0] == 2'h3 |=> wait_o && cnt_ff == 3'h6)
        else $error("i/o wait count wrong");
    mem_bound_a: assert property (
        ce_i && cyc_start_i && cyc_kind_i == CYC_MEM && !in_bound |=> !wait_o)
        else $error("memory wait outside boundary");
    fetch_ext_a: assert property (
        ce_i && cyc_start_i && cyc_kind_i == CYC_FETCH && !in_bound && sif.wait_ctrl[4]
        |=> cnt_ff == 3'h1)
        else $error("fetch extension wait missing");
    ack_wait_a: assert property (
        ce_i && cyc_start_i && cyc_kind_i == CYC_INTACK && chain == 2'h1 && sif.wait_ctrl[5]
        |=> cnt_ff == 3'h3)
        else $error("acknowledge wait count wrong");
    return_wait_a: assert property (
        ce_i && ret_hit && !cyc_start_i && fetch_opcode_i != `OP_RETURN |=> cnt_ff == 3'h1)
        else $error("prefix single wait missing");
endmodule : wait_gen

/* File: watchdog_core.sv */
// watchdog counter with selectable period and timeout pulse
`timescale 1ns/1ps
`include "sysctl_map.svh"
module watchdog_core #(
    parameter int unsigned PERIOD0 = 32'd1 << `WDT_EXP0,
    parameter int unsigned PERIOD1 = 32'd1 << `WDT_EXP1,
    parameter int unsigned PERIOD2 = 32'd1 << `WDT_EXP2,
    parameter int unsigned PERIOD3 = 32'd1 << `WDT_EXP3
) (
    // clock, reset, enable
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    // control from the register bank
    sysctl_if.dog     sif,
    // expiry toward reset logic
    output logic      timeout_o
);
    import sysctl_pkg::*;
    logic [22:0] cnt_ff;
    logic [22:0] limit;
    logic        at_limit;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    always_comb begin
        case (sif.wdt_period)
            2'h0:    limit = PERIOD0[22:0];
            2'h1:    limit = PERIOD1[22:0];
            2'h2:    limit = PERIOD2[22:0];
            default: limit = PERIOD3[22:0];
        endcase
    end
    assign at_limit = (cnt_ff == limit - 23'h1);

    // a clear key in the expiry cycle wins, so software never races the timeout
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_ff    <= '0;
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            timeout_o <= sif.wdt_run && !sif.wdt_clear && at_limit;
            if (sif.wdt_clear || !sif.wdt_run || at_limit) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + 23'h1;
            end
        end
    end

    clear_restart_a: assert property (ce_i && sif.wdt_clear |=> cnt_ff == 23'h0)
        else $error("watchdog count not restarted by clear key");
    expiry_pulse_a: assert property (
        ce_i && sif.wdt_run && !sif.wdt_clear && at_limit |=> timeout_o && cnt_ff == 23'h0)
        else $error("watchdog expiry not flagged");
endmodule : watchdog_core
